// file: cts_top.v
`timescale 1ns/10ps
`default_nettype none
`include "cts_defines.vh"
// channel-triggered output scheduler: delayed step firing on all
// outputs plus timed terminal bindings on ten separate terminal outputs
module cts_top
#(
  parameter TICK_CYC = `CTS_TICK_CYC,
  parameter HAS_STEP = 1,
  parameter HAS_TERM = 1
)
(
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [8:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire fire_valid,
  input wire [9:0] fire_channel,
  input wire loc_wr,
  input wire [9:0] loc_channel,
  input wire [3:0] loc_output,
  input wire [7:0] loc_code,
  input wire loc_clear,
  output reg [99:0] fire_pulse,
  output wire [9:0] term_on,
  output reg step_marker,
  output reg term_marker,
  output wire delays_zero_notice
);
  localparam [31:0] TICK_W = TICK_CYC; // requested tick length
  localparam [31:0] STEP_W = TICK_W * `CTS_TERM_TICKS; // 0.1 s
  // dividers are 28 bits wide, ample for a 0.1 s step at 100 MHz
  localparam [27:0] TICK_C = TICK_W[27:0]; // cycles per 10 ms tick
  localparam [27:0] STEP_C = STEP_W[27:0]; // cycles per 0.1 s step

  reg [2:0] ctrl_q; // firing enable, matrix mode, menu active
  reg notice_q; // delays were cleared by autoassign
  reg strap_q; // markers not yet captured after reset
  reg [9:0] clr_idx_q; // binding memory clear walker address
  reg clr_busy_q; // walker active
  reg trig_q; // binding lookup issued last cycle
  // decoded control bits and shared decode results
  wire fire_en;
  wire matrix;
  wire menu;
  wire term_kill;
  wire auto_wr;
  wire [99:0] busy;
  wire [15:0] out_rd [0:99];
  wire [79:0] term_code;
  wire [99:0] rd_hit;
  wire [9:0] auto_base;
  wire [99:0] pulse_w; // fire flops of all outputs

  // control word fields and the autoassign strobe
  assign fire_en = ctrl_q[`CTS_C_FIRE_EN];
  assign matrix = ctrl_q[`CTS_C_MATRIX];
  assign menu = ctrl_q[`CTS_C_MENU];
  assign auto_wr = reg_wr && reg_addr == `CTS_A_AUTO;
  assign auto_base = reg_wdata[9:0];
  assign delays_zero_notice = notice_q;

  // bindings act only while firing and in ten-output mode
  assign term_kill = menu || !fire_en || matrix;

  // word address of output n's channel or delay register
  function [8:0] out_addr;
    input [8:0] base;
    input [6:0] n;
    begin
      out_addr = base + {2'b00, n};
    end
  endfunction

  // consecutive channel for output n, past the top means unassigned
  function [9:0] auto_chan;
    input [9:0] base;
    input [6:0] n;
    reg [10:0] sum;
    begin
      sum = {1'b0, base} + {4'h0, n};
      if (base == 10'h000 || sum > {1'b0, `CTS_CH_MAX})
        auto_chan = 10'h000;
      else
        auto_chan = sum[9:0];
    end
  endfunction

  // control register and autoassign notice
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `CTS_CTRL_RST;
      notice_q <= 1'b0;
    end
    else if (clk_en)
    begin
      // software sets firing enable, matrix and menu in one word
      if (reg_wr && reg_addr == `CTS_A_CTRL)
        ctrl_q <= reg_wdata[2:0];
      // set by autoassign wins over a write-one clear
      if (auto_wr)
        notice_q <= 1'b1;
      else if (reg_wr && reg_addr == `CTS_A_STAT &&
               reg_wdata[`CTS_S_NOTICE])
        notice_q <= 1'b0;
    end
  end

  // capability markers caught in the first enabled cycle after reset
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_q <= 1'b1;
      step_marker <= 1'b0;
      term_marker <= 1'b0;
    end
    else if (clk_en && strap_q)
    begin
      strap_q <= 1'b0;
      step_marker <= (HAS_STEP != 0);
      term_marker <= (HAS_TERM != 0);
    end
  end

  // per-output step scheduler: channel, delay and a private timer
  genvar g;
  generate
    for (g = 0; g < `CTS_NOUT; g = g + 1)
    begin : g_out
      // output index at the width of the decode functions
      localparam [31:0] IDX_W = g;
      localparam [6:0] IDX = IDX_W[6:0];
      // per-output setup, written over the register port
      reg [9:0] chan_q; // trigger channel, zero is unassigned
      reg pulse_q; // fire flop of this output
      reg [13:0] dly_q; // delay in 10 ms ticks
      reg [13:0] left_q; // ticks left in the running delay
      reg run_q; // delay running
      wire hit; // this output's channel fired
      wire tick; // 10 ms tick counted from this trigger
      wire wr_ch;
      wire wr_dl;

      assign wr_ch = reg_wr && reg_addr == out_addr(`CTS_A_CHAN, IDX);
      assign wr_dl = reg_wr && reg_addr == out_addr(`CTS_A_DLY, IDX);
      // any set of outputs may share a channel
      assign hit = fire_valid && fire_en && !menu &&
                   chan_q != 10'h000 && chan_q == fire_channel;
      assign busy[g] = run_q;
      assign pulse_w[g] = pulse_q;
      assign rd_hit[g] = reg_addr == out_addr(`CTS_A_CHAN, IDX) ||
                         reg_addr == out_addr(`CTS_A_DLY, IDX);
      assign out_rd[g] = reg_addr[7] ? {2'b00, dly_q} :
                         {6'h00, chan_q};

      // tick phase restarts at the trigger, so timing is exact
      cts_tick #(.CW(28), .PERIOD(TICK_C)) u_tick
      (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .restart(hit),
        .tick(tick)
      );

      // programming: each output keeps its own setup
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          chan_q <= 10'h000;
          dly_q <= 14'h0000;
        end
        else if (clk_en)
        begin
          // autoassign overrides a same-cycle register write
          if (auto_wr)
          begin
            chan_q <= auto_chan(auto_base, IDX);
            dly_q <= 14'h0000;
          end
          else
          begin
            if (wr_ch)
              chan_q <= (reg_wdata[9:0] > `CTS_CH_MAX) ? 10'h000 :
                        reg_wdata[9:0];
            if (wr_dl)
              dly_q <= (reg_wdata[13:0] > `CTS_DLY_MAX) ?
                       `CTS_DLY_MAX : reg_wdata[13:0];
          end
        end
      end

      // countdown: loaded at the trigger, fires on expiry
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          run_q <= 1'b0;
          left_q <= 14'h0000;
          pulse_q <= 1'b0;
        end
        else if (clk_en)
        begin
          pulse_q <= 1'b0;
          if (hit)
          begin
            // delay counts from the shared trigger only
            left_q <= dly_q;
            run_q <= (dly_q != 14'h0000);
            // a zero delay fires straight from the trigger
            pulse_q <= (dly_q == 14'h0000);
          end
          else if (menu || !fire_en)
            // halting the firing mode drops pending steps
            run_q <= 1'b0;
          else if (run_q && tick)
          begin
            // one tick down, fire when the last one runs out
            left_q <= left_q - 14'h0001;
            if (left_q == 14'h0001)
            begin
              run_q <= 1'b0;
              pulse_q <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // fire outputs straight from the per-output flops
  always @*
  begin
    fire_pulse = pulse_w;
  end

  // binding memory clear walker: after reset and on local clear
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clr_busy_q <= 1'b1;
      clr_idx_q <= 10'h000;
    end
    else if (clk_en)
    begin
      if (loc_clear)
      begin
        clr_busy_q <= 1'b1;
        clr_idx_q <= 10'h000;
      end
      else if (clr_busy_q)
      begin
        // the walker owns the memory write port while busy
        clr_idx_q <= clr_idx_q + 10'h001;
        // the last address ends the walk
        if (clr_idx_q == 10'h3ff)
          clr_busy_q <= 1'b0;
      end
    end
  end

  // lookup is issued when a channel fires in ten-output mode
  // the looked-up code arrives together with trig_q
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      trig_q <= 1'b0;
    else if (clk_en)
      trig_q <= fire_valid && !term_kill && !clr_busy_q &&
                fire_channel != 10'h000 && (HAS_TERM != 0);
  end

  // terminal outputs: one binding table per output, code per channel
  generate
    for (g = 0; g < `CTS_NTERM; g = g + 1)
    begin : g_term
      // a private binding table per terminal output
      reg [7:0] tmem [0:1023]; // binding code for each channel
      reg [7:0] rcode_q; // code read for the fired channel
      wire lwr;

      // only the local operator port writes bindings
      assign lwr = loc_wr && !clr_busy_q && loc_output == g &&
                   loc_channel != 10'h000 &&
                   loc_channel <= `CTS_CH_MAX;
      assign term_code[g*8 +: 8] = rcode_q;

      // binding memory write and lookup
      always @(posedge sys_clk)
      begin
        if (clk_en)
        begin
          if (clr_busy_q)
            tmem[clr_idx_q] <= `CTS_TC_NONE;
          else if (lwr)
            tmem[loc_channel] <= loc_code;
          rcode_q <= tmem[fire_channel];
        end
      end

      // duration and on/off handling for this output
      cts_term_out #(.CW(28), .STEP_CYC(STEP_C)) u_term
      (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .act(trig_q),
        .code(term_code[g*8 +: 8]),
        .kill(term_kill),
        .on_q(term_on[g])
      );
    end
  endgenerate

  // register read data, valid the cycle after the read strobe
  always @(posedge sys_clk or negedge rst_n)
  begin : p_read
    integer i;
    reg [15:0] v;
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (clk_en && reg_rd)
    begin
      v = 16'h0000;
      for (i = 0; i < `CTS_NOUT; i = i + 1)
        if (rd_hit[i])
          v = out_rd[i];
      // at most one output matches a valid address
      // control and status words
      if (reg_addr == `CTS_A_CTRL)
        v = {13'h0000, ctrl_q};
      else if (reg_addr == `CTS_A_STAT)
        v = {11'h000, clr_busy_q, |busy, term_marker, step_marker,
             notice_q};
      reg_rdata <= v;
    end
  end
endmodule
`default_nettype wire

// file: cts_defines.vh
`ifndef CTS_DEFINES_VH
`define CTS_DEFINES_VH
// clock and tick timing
`define CTS_CLK_NS 10
`define CTS_TICK_NS 10000000
`define CTS_TICK_CYC (`CTS_TICK_NS / `CTS_CLK_NS)
`define CTS_TERM_TICKS 10
// sizes
`define CTS_NOUT 100
`define CTS_NTERM 10
`define CTS_CHW 10
`define CTS_DLYW 14
`define CTS_CH_MAX 10'h3e7
`define CTS_DLY_MAX 14'h270f
// terminal binding codes
`define CTS_TC_NONE 8'h00
`define CTS_TC_DUR_MAX 8'hfa
`define CTS_TC_ON 8'hfe
`define CTS_TC_OFF 8'hff
// register word addresses
`define CTS_A_CHAN 9'h000
`define CTS_A_DLY 9'h080
`define CTS_A_CTRL 9'h100
`define CTS_A_STAT 9'h101
`define CTS_A_AUTO 9'h102
// control fields
`define CTS_C_FIRE_EN 0
`define CTS_C_MATRIX 1
`define CTS_C_MENU 2
`define CTS_CTRL_RST 3'h0
// status fields
`define CTS_S_NOTICE 0
`define CTS_S_STEP 1
`define CTS_S_TERM 2
`define CTS_S_BUSY 3
`define CTS_S_CLR 4
`endif

// file: cts_tick.v
`timescale 1ns/10ps
`default_nettype none
// restartable divider: tick every PERIOD cycles counted from restart
module cts_tick
#(
  parameter CW = 24,
  parameter [CW-1:0] PERIOD = 24'd10
)
(
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire restart,
  output wire tick
);
  reg [CW-1:0] cnt_q; // cycles left in the current tick
  reg [CW-1:0] cnt_d;

  // tick on the last cycle of each period
  assign tick = clk_en && !restart && (cnt_q == {CW{1'b0}});

  // next count: restart aligns the phase to the caller's event
  always @*
  begin
    cnt_d = cnt_q;
    if (restart)
      cnt_d = PERIOD - {{(CW-1){1'b0}}, 1'b1};
    else if (cnt_q == {CW{1'b0}})
      cnt_d = PERIOD - {{(CW-1){1'b0}}, 1'b1};
    else
      cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
  end

  // count register
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= {CW{1'b0}};
    else if (clk_en)
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

// file: cts_term_out.v
`timescale 1ns/10ps
`default_nettype none
`include "cts_defines.vh"
// one terminal output: continuous, timed or forced off by bindings
module cts_term_out
#(
  parameter CW = 28,
  parameter [CW-1:0] STEP_CYC = 28'd100
)
(
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire act,
  input wire [7:0] code,
  input wire kill,
  output reg on_q
);
  reg timed_q; // on for a counted duration
  reg [7:0] left_q; // 0.1 s steps still to run
  wire step; // 0.1 s step, phase set by the activation
  wire start; // a timed activation begins

  assign start = act && !kill && (code != `CTS_TC_NONE) &&
                 (code <= `CTS_TC_DUR_MAX);

  // step divider restarts with each timed activation
  cts_tick #(.CW(CW), .PERIOD(STEP_CYC)) u_step
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .restart(start),
    .tick(step)
  );

  // output state
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_q <= 1'b0;
      timed_q <= 1'b0;
      left_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (kill)
      begin
        // menu entry, matrix mode or firing disabled drops the output
        on_q <= 1'b0;
        timed_q <= 1'b0;
      end
      else if (act && code == `CTS_TC_OFF)
      begin
        on_q <= 1'b0;
        timed_q <= 1'b0;
      end
      else if (act && code == `CTS_TC_ON)
      begin
        on_q <= 1'b1;
        timed_q <= 1'b0;
      end
      else if (start)
      begin
        // hold for code x 0.1 s from this activation
        on_q <= 1'b1;
        timed_q <= 1'b1;
        left_q <= code;
      end
      else if (timed_q && step)
      begin
        left_q <= left_q - 8'h01;
        if (left_q == 8'h01)
        begin
          on_q <= 1'b0;
          timed_q <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: cts_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checker for the scheduler top
module cts_top_chk
#(
  parameter HAS_STEP = 1,
  parameter HAS_TERM = 1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic fire_valid,
  input wire logic [99:0] fire_pulse,
  input wire logic [9:0] term_on,
  input wire logic step_marker,
  input wire logic term_marker,
  input wire logic delays_zero_notice
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // mirror of the control word, fire_en / matrix / menu
  logic [2:0] ctrl_q;
  // write of one to the notice bit
  wire clr_w = clk_en && reg_wr && reg_addr == 9'h101 && reg_wdata[0];
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= 3'h0;
    else if (clk_en && reg_wr && reg_addr == 9'h100)
      ctrl_q <= reg_wdata[2:0];
  end
  mark_step_a: assert property ($past(rst_n) |->
    step_marker == (HAS_STEP != 0)) else $error("step marker wrong");
  mark_term_a: assert property ($past(rst_n) |->
    term_marker == (HAS_TERM != 0)) else $error("term marker wrong");
  notice_set_a: assert property (clk_en && reg_wr && reg_addr == 9'h102 |=>
    delays_zero_notice) else $error("notice not raised");
  notice_hold_a: assert property (delays_zero_notice && !clr_w |=>
    delays_zero_notice) else $error("notice lost");
  status_read_a: assert property (clk_en && reg_rd && reg_addr == 9'h101 |=>
    reg_rdata[2:0] == {$past(term_marker), $past(step_marker),
    $past(delays_zero_notice)}) else $error("status read wrong");
  term_cause_a: assert property (|(term_on & ~$past(term_on)) |->
    $past(fire_valid, 2)) else $error("terminal on without command");
  matrix_off_a: assert property (ctrl_q[1] && $past(ctrl_q[1]) |->
    term_on == 10'h0) else $error("terminal on in matrix mode");
  menu_off_a: assert property ((ctrl_q[2] || !ctrl_q[0]) &&
    $past(ctrl_q[2] || !ctrl_q[0]) |-> term_on == 10'h0 &&
    fire_pulse == 100'h0) else $error("output active while halted");
  // main scenarios
  cover property (|(term_on & ~$past(term_on)));
  cover property (fire_pulse != 100'h0);
  cover property ($rose(delays_zero_notice));
endmodule
bind cts_top cts_top_chk #(.HAS_STEP(HAS_STEP), .HAS_TERM(HAS_TERM)) i_chk
(
  .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata,
  .fire_valid, .fire_pulse, .term_on, .step_marker, .term_marker,
  .delays_zero_notice
);
`default_nettype wire

// file: cts_remote.sv
`timescale 1ns/10ps
`default_nettype none
// remote controller model: sends numbered firing commands
module cts_remote
(
  input wire logic sys_clk,
  output logic fire_valid,
  output logic [9:0] fire_channel
);
  // quiet at time zero
  initial
  begin
    fire_valid = 1'b0;
    fire_channel = 10'h0;
  end
  // one-cycle command, channel scrambled once released
  task automatic send(input logic [9:0] ch);
    @(posedge sys_clk);
    fire_valid <= 1'b1;
    fire_channel <= ch;
    @(posedge sys_clk);
    fire_valid <= 1'b0;
    fire_channel <= ~ch;
  endtask
endmodule
`default_nettype wire

// file: channel_triggered_output_scheduler_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cts_defines.vh"
// compares one value, counts and reports
`define CHK(nm, e, s) \
  begin \
    checks++; \
    if ((s) !== (e)) \
    begin \
      err_count++; \
      $display("mismatch %s exp %0h got %0h", nm, e, s); \
    end \
  end
module channel_triggered_output_scheduler_tb;
  logic sys_clk, rst_n, reg_wr, reg_rd, loc_wr, step_marker, term_marker;
  logic [8:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [9:0] fire_channel, loc_channel, term_on;
  logic [3:0] loc_output;
  logic [7:0] loc_code;
  logic [99:0] fire_pulse;
  logic fire_valid, notice, clk_en, loc_clear;
  int err_count, checks, cyc, on_n;
  int trig_at[1024], pulse_at[100], pulse_n[100];
  // stepping table: output, channel, delay in ticks
  int ot[5] = '{71, 72, 73, 99, 5};
  int ct[5] = '{34, 34, 34, 34, 35};
  int dt[5] = '{0, 1, 3, 9999, 2};
  cts_top #(.TICK_CYC(4)) i_dut
  (
    .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .fire_valid, .fire_channel, .loc_wr,
    .loc_channel, .loc_output, .loc_code, .loc_clear, .fire_pulse,
    .term_on, .step_marker, .term_marker, .delays_zero_notice(notice)
  );
  cts_remote i_rem (.sys_clk, .fire_valid, .fire_channel);
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // time stamps of commands and pulses, terminal on-time
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (fire_valid)
      trig_at[fire_channel] <= cyc;
    for (int n = 0; n < 100; n++)
      if (fire_pulse[n])
      begin
        pulse_at[n] <= cyc;
        pulse_n[n] <= pulse_n[n] + 1;
      end
    if (term_on[8])
      on_n <= on_n + 1;
  end
  task automatic end_of_test();
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // wait whole cycles, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read, then compare the word of the following cycle
  task automatic rc(input string nm, input logic [8:0] a,
    input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    `CHK(nm, e, v)
  endtask
  // local operator binding write
  task automatic lb(input logic [9:0] ch, input logic [3:0] o,
    input logic [7:0] c);
    @(posedge sys_clk);
    loc_wr <= 1'b1;
    loc_channel <= ch;
    loc_output <= o;
    loc_code <= c;
    @(posedge sys_clk);
    loc_wr <= 1'b0;
  endtask
  // hang guard
  initial
  begin
    #600000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 9'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    loc_wr = 1'b0;
    loc_channel = 10'h0;
    loc_output = 4'h0;
    loc_code = 8'h0;
    clk_en = 1'b1;
    loc_clear = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(1040);
    rc("status", `CTS_A_STAT, 16'h0006);
    wr(`CTS_A_DLY + 9'd10, 16'hffff);
    rc("dly_sat", `CTS_A_DLY + 9'd10, 16'h270f);
    wr(`CTS_A_CHAN + 9'd10, 16'h03e8);
    rc("chan_big", `CTS_A_CHAN + 9'd10, 16'h0000);
    rc("unmapped", 9'h1ff, 16'h0000);
    wr(`CTS_A_DLY + 9'd3, 16'h0007);
    wr(`CTS_A_AUTO, 16'h0384);
    rc("auto_ch", `CTS_A_CHAN + 9'd3, 16'h0387);
    rc("auto_dly", `CTS_A_DLY + 9'd3, 16'h0000);
    rc("notice", `CTS_A_STAT, 16'h0007);
    wr(`CTS_A_STAT, 16'h0001);
    rc("notice_clr", `CTS_A_STAT, 16'h0006);
    // shared and separate triggers, delays from the same command
    for (int i = 0; i < 5; i++)
    begin
      wr(`CTS_A_CHAN + 9'(ot[i]), 16'(ct[i]));
      wr(`CTS_A_DLY + 9'(ot[i]), 16'(dt[i]));
    end
    wr(`CTS_A_CTRL, 16'h0001);
    i_rem.send(10'd34);
    i_rem.send(10'd35);
    rc("running", `CTS_A_STAT, 16'h000e);
    tick(40020);
    for (int i = 0; i < 5; i++)
    begin
      `CHK("pulses", 1, pulse_n[ot[i]])
      `CHK("delay", dt[i] * 4 + 1, pulse_at[ot[i]] - trig_at[ct[i]])
    end
    `CHK("unused", 0, pulse_n[70])
    // terminal bindings: timed, on, off
    lb(10'd7, 4'd8, 8'h03);
    lb(10'd46, 4'd5, `CTS_TC_ON);
    lb(10'd53, 4'd5, `CTS_TC_OFF);
    i_rem.send(10'd7);
    tick(200);
    `CHK("duration", 120, on_n)
    i_rem.send(10'd46);
    tick(50);
    `CHK("on", 1'b1, term_on[5])
    i_rem.send(10'd53);
    tick(3);
    `CHK("off", 1'b0, term_on[5])
    i_rem.send(10'd46);
    tick(5);
    wr(`CTS_A_CTRL, 16'h0005);
    tick(3);
    `CHK("menu", 1'b0, term_on[5])
    wr(`CTS_A_CTRL, 16'h0003);
    i_rem.send(10'd7);
    tick(5);
    `CHK("matrix", 10'h000, term_on)
    wr(`CTS_A_CTRL, 16'h0001);
    i_rem.send(10'd7);
    tick(5);
    `CHK("back", 1'b1, term_on[8])
    // 51 frozen edges mid-duration stretch the on-time by as much
    @(posedge sys_clk) clk_en <= 1'b0;
    tick(50);
    @(posedge sys_clk) clk_en <= 1'b1;
    tick(200);
    `CHK("freeze", 120 + 171, on_n)
    wr(`CTS_A_CTRL, 16'h0000);
    i_rem.send(10'd34);
    tick(5);
    `CHK("disabled", 1, pulse_n[71])
    // local clear wipes every binding while it walks the memory
    wr(`CTS_A_CTRL, 16'h0001);
    @(posedge sys_clk) loc_clear <= 1'b1;
    @(posedge sys_clk) loc_clear <= 1'b0;
    rc("clearing", `CTS_A_STAT, 16'h0016);
    tick(1030);
    i_rem.send(10'd7);
    tick(5);
    `CHK("cleared", 10'h000, term_on)
    end_of_test();
  end
endmodule
`default_nettype wire
